// ===== src/mode_switch_defs.vh
// Constants for the real/virtual mode switch interlock checker
//
// Contract
// [R1] Rising request with controller or motion processor not ready: refuse, code 0201.
// [R2] Rising request with all-axes servo-on command off: refuse, code 0202.
// [R3] Rising request with forced stop active: refuse, code 0203.
// [R4] Rising request during servo start after error reset: refuse, code 0204.
// [R5] Rising request with non-roller axis home return request on: refuse, code 0300.
// [R6] Rising request with any axis servo error detected: refuse, code 0400.
// [R7] Rising request with non-roller unit mismatch: refuse, code 0500.
// [R8] Rising request with cam output but no cam data: refuse, code 0600.
// [R9] Rising request with cam number setting zero: refuse, code 0800. Checked only when some axis selects a cam.
// [R10] Cam stroke outside 1 to 2^31-1: refuse, code 0900. Checked only when some axis selects a cam.
// [R11] Cam stroke odd: refuse, code 0B00. Checked only when some axis selects a cam.
// [R12] Real mode axis configuration invalid: refuse, code 0C00.
// [R13] In virtual mode, controller or processor not ready: back to real, code F002.
// [R14] In virtual mode, servo error detect change: back to real, code F001.
// [R15] In virtual mode, forced stop active: back to real, code F000.
// [R16] Codes 0201-0204 and F000-F002 leave error axis info untouched.
// [R17] Sequence program waits for servo error detect off before requesting again. The bench model waits only after an error reset, and for at most 8 cycles.
// [R18] Request edge while any axis moving: refuse, 0001 rising, 0100 falling.
// [R19] Checks run once per rising edge; one code stored by fixed priority.
`ifndef MODE_SWITCH_DEFS_VH
`define MODE_SWITCH_DEFS_VH

`define NUM_AXES        8

// Register byte offsets
`define REG_STATUS      6'h00
`define REG_ERR_CODE    6'h04
`define REG_AXIS_LO     6'h08
`define REG_AXIS_HI     6'h0c
`define REG_ROLLER      6'h10
`define REG_CAM_SEL     6'h14
`define REG_CAM_LOADED  6'h18
`define REG_UNIT_DIFF   6'h1c
`define REG_CAM_NO      6'h20
`define REG_CAM_STROKE  6'h24
`define REG_REAL_CFG    6'h28
`define REG_IRQ_STAT    6'h2c
`define REG_IRQ_CLR     6'h30
`define REG_IRQ_EN      6'h34

// Interrupt status bit positions
`define IRQ_REFUSED     0
`define IRQ_ENTERED     1
`define IRQ_FORCED      2
`define IRQ_LEFT        3
`define IRQ_W           4

// Reset values
`define RST_CODE        16'h0000
`define RST_REAL_CFG    1'b1

// Error codes
`define EC_NONE         16'h0000
`define EC_NOT_STOP_ON  16'h0001
`define EC_NOT_STOP_OFF 16'h0100
`define EC_NOT_READY    16'h0201
`define EC_SERVO_OFF    16'h0202
`define EC_FSTOP        16'h0203
`define EC_SERVO_START  16'h0204
`define EC_HOME_REQ     16'h0300
`define EC_SERVO_ERR    16'h0400
`define EC_UNIT         16'h0500
`define EC_NO_CAM       16'h0600
`define EC_CAM_NO       16'h0800
`define EC_STROKE_RNG   16'h0900
`define EC_STROKE_ODD   16'h0b00
`define EC_REAL_AXIS    16'h0c00
`define EC_V_FSTOP      16'hf000
`define EC_V_SERVO      16'hf001
`define EC_V_READY      16'hf002

`endif

// ===== src/pin_sync.v
// Two-stage synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
	parameter W = 1
) (
	// Clock and reset
	input  wire         mclk_i,
	input  wire         arst_n_i,
	// Pins and synchronised copy
	input  wire [W-1:0] pin_i,
	output wire [W-1:0] sync_o
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	always @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end
		else
		begin
			meta_ff <= pin_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;
endmodule

// ===== src/switch_check.v
// Combinational switch checks: picks one code by fixed priority plus the failing axes
`timescale 1ns/1ps
`include "mode_switch_defs.vh"
module switch_check (
	// Flags
	input  wire                  ctrl_rdy_i,
	input  wire                  mp_rdy_i,
	input  wire                  servo_on_i,
	input  wire                  fstop_i,
	// Per-axis state
	input  wire [`NUM_AXES-1:0]  moving_i,
	input  wire [`NUM_AXES-1:0]  err_reset_i,
	input  wire [`NUM_AXES-1:0]  err_det_i,
	input  wire [`NUM_AXES-1:0]  home_req_i,
	// Configuration
	input  wire [`NUM_AXES-1:0]  roller_i,
	input  wire [`NUM_AXES-1:0]  cam_sel_i,
	input  wire [`NUM_AXES-1:0]  cam_loaded_i,
	input  wire [`NUM_AXES-1:0]  unit_diff_i,
	input  wire [15:0]           cam_no_i,
	input  wire [31:0]           cam_stroke_i,
	input  wire                  real_cfg_ok_i,
	// Result
	output reg  [15:0]           code_o,
	output reg  [`NUM_AXES-1:0]  axes_o
);
	wire [`NUM_AXES-1:0] home_fail;
	wire [`NUM_AXES-1:0] unit_fail;
	wire [`NUM_AXES-1:0] cam_fail;
	wire                 cam_used;

	genvar g;
	generate
		for (g = 0; g < `NUM_AXES; g = g + 1)
		begin : g_axis
			assign home_fail[g] = home_req_i[g] & ~roller_i[g]; // R5
			assign unit_fail[g] = unit_diff_i[g] & ~roller_i[g]; // R7
			assign cam_fail[g]  = cam_sel_i[g] & ~cam_loaded_i[g]; // R8
		end
	endgenerate

	// Cam number and stroke settings only matter when some axis drives a cam
	assign cam_used = |cam_sel_i;

	always @*
	begin
		code_o = `EC_NONE;
		axes_o = {`NUM_AXES{1'b0}};
		if (|moving_i) // R18
		begin
			code_o = `EC_NOT_STOP_ON;
			axes_o = moving_i;
		end
		else if (!ctrl_rdy_i || !mp_rdy_i) // R1
			code_o = `EC_NOT_READY;
		else if (!servo_on_i) // R2
			code_o = `EC_SERVO_OFF;
		else if (fstop_i) // R3
			code_o = `EC_FSTOP;
		else if (|err_reset_i) // R4
			code_o = `EC_SERVO_START;
		else if (|home_fail) // R5
		begin
			code_o = `EC_HOME_REQ;
			axes_o = home_fail;
		end
		else if (|err_det_i) // R6
		begin
			code_o = `EC_SERVO_ERR;
			axes_o = err_det_i;
		end
		else if (|unit_fail) // R7
		begin
			code_o = `EC_UNIT;
			axes_o = unit_fail;
		end
		else if (|cam_fail) // R8
		begin
			code_o = `EC_NO_CAM;
			axes_o = cam_fail;
		end
		else if (cam_used && cam_no_i == 16'h0000) // R9
			code_o = `EC_CAM_NO;
		else if (cam_used && (cam_stroke_i == 32'h0000_0000 || cam_stroke_i[31])) // R10
			code_o = `EC_STROKE_RNG;
		else if (cam_used && cam_stroke_i[0]) // R11
			code_o = `EC_STROKE_ODD;
		else if (!real_cfg_ok_i) // R12
			code_o = `EC_REAL_AXIS;
	end
endmodule

// ===== src/mode_switch_interlock_checker.v
// Real/virtual mode switch interlock with Avalon-MM register slave and interrupt
`timescale 1ns/1ps
`include "mode_switch_defs.vh"
module mode_switch_interlock_checker (
	// Clock and reset
	input  wire                  mclk_i,
	input  wire                  arst_n_i,
	// Avalon-MM slave
	input  wire [5:0]            avs_address_i,
	input  wire                  avs_read_i,
	input  wire                  avs_write_i,
	input  wire [31:0]           avs_writedata_i,
	output reg  [31:0]           avs_readdata_o,
	output wire                  avs_waitrequest_o,
	// Sequence program flags
	input  wire                  mode_switch_request_i,
	input  wire                  controller_ready_flag_i,
	input  wire                  motion_processor_ready_flag_i,
	input  wire                  all_axes_servo_on_cmd_i,
	input  wire                  forced_stop_input_i,
	// Per-axis signals
	input  wire [`NUM_AXES-1:0]  axis_start_accept_i,
	input  wire [`NUM_AXES-1:0]  axis_servo_error_reset_cmd_i,
	input  wire [`NUM_AXES-1:0]  axis_servo_error_detect_i,
	input  wire [`NUM_AXES-1:0]  axis_home_return_request_i,
	// Mode and status
	output wire                  virtual_mode_o,
	output wire [15:0]           mode_switch_error_code_o,
	output wire [15:0]           error_axis_info_low_o,
	output wire [15:0]           error_axis_info_high_o,
	output wire                  irq_o
);
	localparam NA = `NUM_AXES;
	localparam SW = 5 + 4 * NA;

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	wire [SW-1:0] pins_raw;
	wire [SW-1:0] pins_s;

	assign pins_raw = {mode_switch_request_i,
	                   controller_ready_flag_i,
	                   motion_processor_ready_flag_i,
	                   all_axes_servo_on_cmd_i,
	                   forced_stop_input_i,
	                   axis_start_accept_i,
	                   axis_servo_error_reset_cmd_i,
	                   axis_servo_error_detect_i,
	                   axis_home_return_request_i};

	// Every pin crosses two flops first, so a pin edge is judged three edges late
	pin_sync #(
		.W(SW)
	) u_sync (
		.mclk_i  (mclk_i),
		.arst_n_i(arst_n_i),
		.pin_i   (pins_raw),
		.sync_o  (pins_s)
	);

	wire          req_s;
	wire          ctrl_rdy_s;
	wire          mp_rdy_s;
	wire          servo_on_s;
	wire          fstop_s;
	wire [NA-1:0] moving_s;
	wire [NA-1:0] err_reset_s;
	wire [NA-1:0] err_det_s;
	wire [NA-1:0] home_req_s;

	assign req_s       = pins_s[SW-1];
	assign ctrl_rdy_s  = pins_s[SW-2];
	assign mp_rdy_s    = pins_s[SW-3];
	assign servo_on_s  = pins_s[SW-4];
	assign fstop_s     = pins_s[SW-5];
	assign moving_s    = pins_s[4*NA-1:3*NA];
	assign err_reset_s = pins_s[3*NA-1:2*NA];
	assign err_det_s   = pins_s[2*NA-1:NA];
	assign home_req_s  = pins_s[NA-1:0];

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	reg  [NA-1:0]     roller_ff;
	reg  [NA-1:0]     cam_sel_ff;
	reg  [NA-1:0]     cam_loaded_ff;
	reg  [NA-1:0]     unit_diff_ff;
	reg  [15:0]       cam_no_ff;
	reg  [31:0]       cam_stroke_ff;
	reg               real_cfg_ff;
	reg  [`IRQ_W-1:0] irq_stat_ff;
	reg  [`IRQ_W-1:0] irq_en_ff;
	reg               ack_ff;
	reg  [31:0]       nxt_rdata;

	wire              bus_req;
	wire              wr_en;
	wire [`IRQ_W-1:0] irq_clr;

	// One wait state: the answer is given on the second edge of every access
	assign bus_req           = avs_read_i | avs_write_i;
	assign avs_waitrequest_o = bus_req & ~ack_ff;
	assign wr_en             = avs_write_i & ack_ff;
	assign irq_clr           = (wr_en && avs_address_i == `REG_IRQ_CLR) ?
	                           avs_writedata_i[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

	// Toggling ack gives every back-to-back request its own wait state
	always @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			ack_ff <= 1'b0;
		else
			ack_ff <= bus_req & ~ack_ff;
	end

	// ------------------------------------------------------------
	// Mode state and error registers
	// ------------------------------------------------------------
	reg           virtual_ff;
	reg           req_d_ff;
	reg  [NA-1:0] err_det_d_ff;
	reg  [15:0]   code_ff;
	reg  [15:0]   axis_lo_ff;
	reg  [15:0]   axis_hi_ff;
	reg           nxt_virtual;
	reg  [15:0]   nxt_code;
	reg  [15:0]   nxt_axis_lo;
	reg  [15:0]   nxt_axis_hi;

	wire [15:0]   chk_code;
	wire [NA-1:0] chk_axes;
	wire          req_rise;
	wire          req_fall;
	wire          v_fstop;
	wire          v_servo;
	wire          v_ready;
	wire          refuse_on;
	wire          refuse_off;
	wire          enter_ok;
	wire          leave_ok;
	wire          forced;

	switch_check u_check (
		.ctrl_rdy_i   (ctrl_rdy_s),
		.mp_rdy_i     (mp_rdy_s),
		.servo_on_i   (servo_on_s),
		.fstop_i      (fstop_s),
		.moving_i     (moving_s),
		.err_reset_i  (err_reset_s),
		.err_det_i    (err_det_s),
		.home_req_i   (home_req_s),
		.roller_i     (roller_ff),
		.cam_sel_i    (cam_sel_ff),
		.cam_loaded_i (cam_loaded_ff),
		.unit_diff_i  (unit_diff_ff),
		.cam_no_i     (cam_no_ff),
		.cam_stroke_i (cam_stroke_ff),
		.real_cfg_ok_i(real_cfg_ff),
		.code_o       (chk_code),
		.axes_o       (chk_axes)
	);

	assign req_rise = req_s & ~req_d_ff;
	assign req_fall = ~req_s & req_d_ff;

	// Forced returns only watched while virtual
	assign v_fstop = virtual_ff & fstop_s; // R15
	assign v_servo = virtual_ff & (|(err_det_s ^ err_det_d_ff)); // R14
	assign v_ready = virtual_ff & (~ctrl_rdy_s | ~mp_rdy_s); // R13
	assign forced  = v_fstop | v_servo | v_ready;

	// Switch requests are only judged in the matching mode
	assign refuse_on  = ~virtual_ff & req_rise & (chk_code != `EC_NONE); // R19
	assign enter_ok   = ~virtual_ff & req_rise & (chk_code == `EC_NONE); // R19
	assign refuse_off = virtual_ff & ~forced & req_fall & (|moving_s); // R18
	assign leave_ok   = virtual_ff & ~forced & req_fall & ~(|moving_s);

	// Error codes are never cleared; the next error overwrites
	always @*
	begin
		nxt_virtual = virtual_ff;
		nxt_code    = code_ff;
		nxt_axis_lo = axis_lo_ff;
		nxt_axis_hi = axis_hi_ff;
		// Forced return outranks any request edge in the same cycle
		if (v_fstop)
		begin
			nxt_virtual = 1'b0;
			nxt_code    = `EC_V_FSTOP; // R15 R16
		end
		else if (v_servo)
		begin
			nxt_virtual = 1'b0;
			nxt_code    = `EC_V_SERVO; // R14 R16
		end
		else if (v_ready)
		begin
			nxt_virtual = 1'b0;
			nxt_code    = `EC_V_READY; // R13 R16
		end
		else if (refuse_on)
		begin
			nxt_code = chk_code; // R19
			// Axis info kept for the 02xx codes, which name no axis
			if (chk_axes != {NA{1'b0}}) // R16
			begin
				nxt_axis_lo = {{(16-NA){1'b0}}, chk_axes};
				nxt_axis_hi = 16'h0000;
			end
		end
		else if (enter_ok)
			nxt_virtual = 1'b1;
		else if (refuse_off)
		begin
			nxt_code    = `EC_NOT_STOP_OFF; // R18
			nxt_axis_lo = {{(16-NA){1'b0}}, moving_s};
			nxt_axis_hi = 16'h0000;
		end
		else if (leave_ok)
			nxt_virtual = 1'b0;
	end

	always @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			virtual_ff   <= 1'b0;
			req_d_ff     <= 1'b0;
			err_det_d_ff <= {NA{1'b0}};
			code_ff      <= `RST_CODE;
			axis_lo_ff   <= 16'h0000;
			axis_hi_ff   <= 16'h0000;
		end
		else
		begin
			req_d_ff     <= req_s;
			err_det_d_ff <= err_det_s;
			virtual_ff   <= nxt_virtual;
			code_ff      <= nxt_code;
			axis_lo_ff   <= nxt_axis_lo;
			axis_hi_ff   <= nxt_axis_hi;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	wire [`IRQ_W-1:0] irq_set;

	assign irq_set[`IRQ_REFUSED] = refuse_on | refuse_off;
	assign irq_set[`IRQ_ENTERED] = enter_ok;
	assign irq_set[`IRQ_FORCED]  = forced;
	assign irq_set[`IRQ_LEFT]    = leave_ok;

	always @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			roller_ff     <= {NA{1'b0}};
			cam_sel_ff    <= {NA{1'b0}};
			cam_loaded_ff <= {NA{1'b0}};
			unit_diff_ff  <= {NA{1'b0}};
			cam_no_ff     <= 16'h0000;
			cam_stroke_ff <= 32'h0000_0000;
			real_cfg_ff   <= `RST_REAL_CFG;
			irq_en_ff     <= {`IRQ_W{1'b0}};
		end
		else
		begin
			if (wr_en)
			begin
				case (avs_address_i)
					`REG_ROLLER:     roller_ff     <= avs_writedata_i[NA-1:0];
					`REG_CAM_SEL:    cam_sel_ff    <= avs_writedata_i[NA-1:0];
					`REG_CAM_LOADED: cam_loaded_ff <= avs_writedata_i[NA-1:0];
					`REG_UNIT_DIFF:  unit_diff_ff  <= avs_writedata_i[NA-1:0];
					`REG_CAM_NO:     cam_no_ff     <= avs_writedata_i[15:0];
					`REG_CAM_STROKE: cam_stroke_ff <= avs_writedata_i;
					`REG_REAL_CFG:   real_cfg_ff   <= avs_writedata_i[0];
					`REG_IRQ_EN:     irq_en_ff     <= avs_writedata_i[`IRQ_W-1:0];
					default:         ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------
	// A new event in the clearing cycle stays set
	always @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			irq_stat_ff <= {`IRQ_W{1'b0}};
		else
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Unmapped and write-only addresses read as zero
	always @*
	begin
		nxt_rdata = 32'h0000_0000;
		case (avs_address_i)
			`REG_STATUS:     nxt_rdata = {31'h0000_0000, virtual_ff};
			`REG_ERR_CODE:   nxt_rdata = {16'h0000, code_ff};
			`REG_AXIS_LO:    nxt_rdata = {16'h0000, axis_lo_ff};
			`REG_AXIS_HI:    nxt_rdata = {16'h0000, axis_hi_ff};
			`REG_ROLLER:     nxt_rdata = {{(32-NA){1'b0}}, roller_ff};
			`REG_CAM_SEL:    nxt_rdata = {{(32-NA){1'b0}}, cam_sel_ff};
			`REG_CAM_LOADED: nxt_rdata = {{(32-NA){1'b0}}, cam_loaded_ff};
			`REG_UNIT_DIFF:  nxt_rdata = {{(32-NA){1'b0}}, unit_diff_ff};
			`REG_CAM_NO:     nxt_rdata = {16'h0000, cam_no_ff};
			`REG_CAM_STROKE: nxt_rdata = cam_stroke_ff;
			`REG_REAL_CFG:   nxt_rdata = {31'h0000_0000, real_cfg_ff};
			`REG_IRQ_STAT:   nxt_rdata = {{(32-`IRQ_W){1'b0}}, irq_stat_ff};
			`REG_IRQ_EN:     nxt_rdata = {{(32-`IRQ_W){1'b0}}, irq_en_ff};
			default:         nxt_rdata = 32'h0000_0000;
		endcase
	end

	// Read data captured on the first edge so it stands at the accepting edge
	always @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			avs_readdata_o <= 32'h0000_0000;
		else if (avs_read_i && !ack_ff)
			avs_readdata_o <= nxt_rdata;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign virtual_mode_o           = virtual_ff;
	assign mode_switch_error_code_o = code_ff;
	assign error_axis_info_low_o    = axis_lo_ff;
	assign error_axis_info_high_o   = axis_hi_ff;
	// Level interrupt: high while any enabled status bit is set
	assign irq_o                    = |(irq_stat_ff & irq_en_ff);
endmodule

// ===== bench/mode_switch_asserts.sv
// Concurrent checks on the ports of the mode switch interlock
`timescale 1ns/1ps
`include "mode_switch_defs.vh"
module mode_switch_asserts (
	// Clock and reset
	input	wire logic			mclk_i,
	input	wire logic			arst_n_i,
	// Watched inputs
	input	wire logic			avs_read_i,
	input	wire logic			avs_write_i,
	input	wire logic			controller_ready_flag_i,
	input	wire logic			all_axes_servo_on_cmd_i,
	input	wire logic			forced_stop_input_i,
	input	wire logic [`NUM_AXES-1:0]	axis_start_accept_i,
	input	wire logic [`NUM_AXES-1:0]	axis_servo_error_detect_i,
	// Watched outputs
	input	wire logic			avs_waitrequest_o,
	input	wire logic			virtual_mode_o,
	input	wire logic [15:0]		mode_switch_error_code_o,
	input	wire logic [15:0]		error_axis_info_low_o,
	input	wire logic [15:0]		error_axis_info_high_o,
	input	wire logic			irq_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	// ------------------------------
	// Properties
	// ------------------------------
	enter_code_a: assert property ($rose(virtual_mode_o) |-> $stable(mode_switch_error_code_o))
		else $error("code changed on entering virtual mode");
	info_keep_a: assert property ($changed(mode_switch_error_code_o) &&
		(mode_switch_error_code_o[15:8] == 8'h02 || mode_switch_error_code_o[15:12] == 4'hf)
		|-> $stable(error_axis_info_low_o) && $stable(error_axis_info_high_o))
		else $error("axis info written with a flag-only code");
	forced_fall_a: assert property ($changed(mode_switch_error_code_o) &&
		mode_switch_error_code_o[15:12] == 4'hf |-> $fell(virtual_mode_o))
		else $error("forced code without return to real mode");
	fstop_real_a: assert property (forced_stop_input_i [*8] |-> !virtual_mode_o)
		else $error("virtual mode held under forced stop");
	ready_real_a: assert property (!controller_ready_flag_i [*8] |-> !virtual_mode_o)
		else $error("virtual mode held without controller ready");
	servo_off_a: assert property (!all_axes_servo_on_cmd_i [*8] |-> !$rose(virtual_mode_o))
		else $error("entered virtual mode with servo off");
	err_block_a: assert property ((|axis_servo_error_detect_i) [*8] |-> !$rose(virtual_mode_o))
		else $error("entered virtual mode with servo error");
	moving_block_a: assert property ((|axis_start_accept_i) [*8] |-> !$rose(virtual_mode_o))
		else $error("entered virtual mode with an axis moving");
	bus_wait_a: assert property ($rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("bus access without exactly one wait state");
	enter_c: cover property ($rose(virtual_mode_o));
	forced_c: cover property ($changed(mode_switch_error_code_o) && mode_switch_error_code_o == 16'hf000);
	irq_c: cover property ($rose(irq_o));
endmodule
bind mode_switch_interlock_checker mode_switch_asserts u_mode_switch_asserts (
	.mclk_i(mclk_i), .arst_n_i(arst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.controller_ready_flag_i(controller_ready_flag_i), .all_axes_servo_on_cmd_i(all_axes_servo_on_cmd_i),
	.forced_stop_input_i(forced_stop_input_i), .axis_start_accept_i(axis_start_accept_i),
	.axis_servo_error_detect_i(axis_servo_error_detect_i), .avs_waitrequest_o(avs_waitrequest_o),
	.virtual_mode_o(virtual_mode_o), .mode_switch_error_code_o(mode_switch_error_code_o),
	.error_axis_info_low_o(error_axis_info_low_o), .error_axis_info_high_o(error_axis_info_high_o),
	.irq_o(irq_o)
);

// ===== bench/seq_program_model.sv
// Sequence program model driving the request and status flags
`timescale 1ns/1ps
`include "mode_switch_defs.vh"
module seq_program_model (
	// Clock
	input	wire logic			mclk_i,
	// Flags and per-axis lines
	output	logic				req_o,
	output	logic [3:0]			flag_o,
	output	logic [`NUM_AXES-1:0]		acc_o,
	output	logic [`NUM_AXES-1:0]		rst_o,
	output	logic [`NUM_AXES-1:0]		det_o,
	output	logic [`NUM_AXES-1:0]		home_o
);
	logic	after_rst = 1'h0;
	// All pins low through reset, as the interlock expects
	initial
	begin
		req_o = 1'h0;
		flag_o = 4'h0;
		{acc_o, rst_o, det_o, home_o} = '0;
	end
	task set_pins(input logic [3:0] f, input logic [7:0] a, input logic [7:0] r, input logic [7:0] d,
		input logic [7:0] h);
		begin
			flag_o <= f;
			{acc_o, rst_o, det_o, home_o} <= {a, r, d, h};
			if (|r)
				after_rst = 1'h1;
			@(posedge mclk_i);
		end
	endtask
	// After an error reset the program holds off until detect has dropped or 8 cycles have passed
	task raise(input logic v);
		integer n;
		begin
			n = 0;
			while (v && after_rst && (|det_o) && n < 8)
			begin
				@(posedge mclk_i);
				n++;
			end
			after_rst = 1'h0;
			req_o <= v;
			@(posedge mclk_i);
		end
	endtask
endmodule

// ===== bench/mode_switch_interlock_checker_tb.sv
// Self-checking bench for the mode switch interlock checker
`timescale 1ns/1ps
`include "mode_switch_defs.vh"
module mode_switch_interlock_checker_tb;
	logic		mclk_i = 1'h0;
	logic		arst_n_i = 1'h0;
	logic [5:0]	addr = 6'h00;
	logic		rd = 1'h0;
	logic		wr = 1'h0;
	logic [31:0]	wdata = 32'h0;
	wire [31:0]	rdata;
	wire		waitreq, req, virt, irq;
	wire [3:0]	fl;
	wire [7:0]	acc, rst, det, home;
	wire [15:0]	code, info, info_hi;
	logic [7:0]	a_v, d_v, h_v;
	logic [15:0]	oc, oi;
	logic [31:0]	rv;
	logic [31:0]	cfg [0:6];
	logic [67:0]	rows [0:18];
	integer		checks = 0;
	integer		n_mismatch = 0;
	integer		i;
	always #4 mclk_i = ~mclk_i;
	mode_switch_interlock_checker u_mode_switch_interlock_checker (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
		.mode_switch_request_i(req), .controller_ready_flag_i(fl[3]), .motion_processor_ready_flag_i(fl[2]),
		.all_axes_servo_on_cmd_i(fl[1]), .forced_stop_input_i(fl[0]), .axis_start_accept_i(acc),
		.axis_servo_error_reset_cmd_i(rst), .axis_servo_error_detect_i(det), .axis_home_return_request_i(home),
		.virtual_mode_o(virt), .mode_switch_error_code_o(code), .error_axis_info_low_o(info),
		.error_axis_info_high_o(info_hi), .irq_o(irq));
	seq_program_model u_seq_program_model (.mclk_i(mclk_i), .req_o(req), .flag_o(fl), .acc_o(acc),
		.rst_o(rst), .det_o(det), .home_o(home));
	task stop_test;
		begin
			$display("checks %0d n_mismatch %0d", checks, n_mismatch);
			if (n_mismatch == 0 && checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		begin
			checks++;
			if (seen !== exp)
			begin
				n_mismatch++;
				$display("wrong value %s expected %h seen %h", name, exp, seen);
			end
		end
	endtask
	// Bounded waits: a run that hangs counts as a mismatch
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		integer n;
		begin
			{addr, wdata, wr, rd} <= {a, d, w, !w};
			n = 0;
			do
			begin
				@(posedge mclk_i);
				n++;
			end
			while (waitreq !== 1'h0 && n < 16);
			rv = rdata;
			{wr, rd} <= 2'h0;
			chk("bus done", n < 16, 32'h1);
			if (n >= 16)
				stop_test;
			@(posedge mclk_i);
		end
	endtask
	task settle(input logic [15:0] c, input logic v);
		integer n;
		begin
			n = 0;
			while (code === c && virt === v && n < 16)
			begin
				@(posedge mclk_i);
				n++;
			end
			if (n >= 16)
			begin
				chk("response", 32'h0, 32'h1);
				stop_test;
			end
		end
	endtask
	task apply(input logic [3:0] k, input logic [31:0] v);
		logic [3:0] f;
		logic [7:0] r;
		begin
			f = 4'he;
			{a_v, r, d_v, h_v} = '0;
			cfg = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h1, 32'h2, 32'h1};
			case (k)
				4'h0: f[3] = 1'h0;
				4'h1: f[2] = 1'h0;
				4'h2: f[1] = 1'h0;
				4'h3: f[0] = 1'h1;
				4'h4: r = v[7:0];
				4'h5: h_v = v[7:0];
				4'h6: d_v = v[7:0];
				4'h7: cfg[3] = v;
				4'h8: cfg[1] = v | 32'h1;
				4'h9: cfg[4] = v;
				4'ha: cfg[5] = v;
				4'hb: cfg[6] = 32'h0;
				4'hc: a_v = v[7:0];
				4'hd: {cfg[0], h_v} = {v, v[7:0]};
				4'hf: {f[3], h_v} = {1'h0, 8'h02};
				default: ;
			endcase
			for (int j = 0; j < 7; j++)
				bus(1'h1, `REG_ROLLER + 6'(4 * j), cfg[j]);
			u_seq_program_model.set_pins(f, a_v, r, d_v, h_v);
			repeat (4) @(posedge mclk_i);
			{oc, oi} = {code, info};
			u_seq_program_model.raise(1'h1);
			settle(oc, 1'h0);
		end
	endtask
	task fire(input logic [3:0] f, input logic [7:0] d, input logic [15:0] ec);
		begin
			bus(1'h1, `REG_IRQ_CLR, 32'hf);
			bus(1'h1, `REG_IRQ_EN, 32'h4);
			{oc, oi} = {code, info};
			u_seq_program_model.set_pins(f, 8'h00, 8'h00, d, 8'h00);
			settle(oc, 1'h1);
			chk("forced", {virt, code}, {1'h0, ec});
			chk("forced info", info, oi);
			chk("irq", irq, 32'h1);
			bus(1'h0, `REG_IRQ_STAT, 32'h0);
			chk("irq status", rv, 32'h4);
			bus(1'h1, `REG_IRQ_EN, 32'h0);
			chk("irq masked", irq, 32'h0);
			bus(1'h1, `REG_IRQ_CLR, 32'h4);
			bus(1'h1, `REG_IRQ_EN, 32'h4);
			chk("irq cleared", irq, 32'h0);
			u_seq_program_model.raise(1'h0);
		end
	endtask
	initial
	begin
		// Rows: knob, knob value, code (0 means enter), axis info (ffff means untouched)
		rows = '{{4'he, 32'h0, 16'h0, 16'hffff}, {4'h0, 32'h0, 16'h0201, 16'hffff},
			{4'h2, 32'h0, 16'h0202, 16'hffff}, {4'h1, 32'h0, 16'h0201, 16'hffff},
			{4'h3, 32'h0, 16'h0203, 16'hffff}, {4'h4, 32'h1, 16'h0204, 16'hffff},
			{4'h5, 32'h2, 16'h0300, 16'h0002}, {4'h6, 32'h4, 16'h0400, 16'h0004},
			{4'h7, 32'h8, 16'h0500, 16'h0008}, {4'h8, 32'h10, 16'h0600, 16'h0010},
			{4'h9, 32'h0, 16'h0800, 16'hffff}, {4'ha, 32'h0, 16'h0900, 16'hffff},
			{4'ha, 32'h1, 16'h0b00, 16'hffff}, {4'ha, 32'h80000000, 16'h0900, 16'hffff},
			{4'hb, 32'h0, 16'h0c00, 16'hffff}, {4'hf, 32'h0, 16'h0201, 16'hffff},
			{4'hc, 32'h80, 16'h0001, 16'h0080}, {4'ha, 32'h7ffffffe, 16'h0, 16'hffff},
			{4'hd, 32'h2, 16'h0, 16'hffff}};
		repeat (12) @(posedge mclk_i);
		arst_n_i <= 1'h1;
		@(posedge mclk_i);
		chk("reset outputs", {virt, irq, code}, 32'h0);
		chk("reset info", {info_hi, info}, 32'h0);
		bus(1'h0, `REG_REAL_CFG, 32'h0);
		chk("real cfg reset", rv, 32'h1);
		bus(1'h1, `REG_ERR_CODE, 32'hffff);
		bus(1'h0, `REG_ERR_CODE, 32'h0);
		chk("read-only code", rv, 32'h0);
		bus(1'h0, 6'h3c, 32'h0);
		chk("unmapped", rv, 32'h0);
		for (i = 0; i < 19; i++)
		begin
			apply(rows[i][67:64], rows[i][63:32]);
			chk("mode", {virt, code}, {rows[i][31:16] == 16'h0, (rows[i][31:16] == 16'h0) ? oc : rows[i][31:16]});
			chk("info", {info_hi, info}, {16'h0, (rows[i][15:0] == 16'hffff) ? oi : rows[i][15:0]});
			oc = code;
			u_seq_program_model.raise(1'h0);
			if (virt === 1'h1)
				settle(oc, 1'h1);
			chk("left", {virt, code}, {1'h0, oc});
		end
		apply(4'he, 32'h0);
		fire(4'hf, 8'h00, 16'hf000);
		apply(4'he, 32'h0);
		fire(4'he, 8'h01, 16'hf001);
		apply(4'he, 32'h0);
		fire(4'h6, 8'h00, 16'hf002);
		apply(4'he, 32'h0);
		u_seq_program_model.set_pins(4'he, 8'h01, 8'h00, 8'h00, 8'h00);
		repeat (4) @(posedge mclk_i);
		oc = code;
		u_seq_program_model.raise(1'h0);
		settle(oc, 1'h1);
		chk("falling refused", {virt, code}, {1'h1, 16'h0100});
		chk("refused info", info, 16'h0001);
		fire(4'hf, 8'h00, 16'hf000);
		stop_test;
	end
endmodule
